// *** src/peripheral_pid_access_guard.sv ***
// Peripheral access guard keyed on the running process identifier
//
// Behaviour
// - Each of 41 peripherals checked individually
// - Identifiers 0 and 1 granted on all 41 peripherals
// - Identifiers 2-7 granted only when bit set
// - Identifiers 2..7 map onto bits 0..5
// - Only identifiers 0/1 may write entries
// - Interrupt vector fetch counts as identifier 0
`timescale 1ns/1ps
`include "access_guard_params.svh"

module peripheral_pid_access_guard (
   input  wire logic                          ref_clk,
   input  wire logic                          arst_n,
   // Avalon-MM slave
   input  wire logic [`ADDR_W-1:0]            avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   input  wire logic [`PID_W-1:0]             avs_pid,
   output logic      [31:0]                   avs_readdata,
   output logic                               avs_waitrequest,
   // Access check port
   input  wire logic                          chk_valid,
   input  wire access_guard_pkg::access_req_t chk_req,
   output access_guard_pkg::access_resp_t     chk_resp
);

   // Permission table, one entry per configurable peripheral
   logic [`PERM_W-1:0] perm_q [`NUM_ENTRY];
   logic [`PERM_W-1:0] perm_d [`NUM_ENTRY];

   // Bus answer state
   logic               wait_q;
   logic               wait_d;
   logic [31:0]        rdata_q;
   logic [31:0]        rdata_d;

   // Check result and refusal log
   access_guard_pkg::access_resp_t resp_q;
   access_guard_pkg::access_resp_t resp_d;
   access_guard_pkg::refuse_log_t  log_q;
   access_guard_pkg::refuse_log_t  log_d;

   // Bus decode
   logic               bus_req;
   logic               commit;
   logic               in_table;
   logic               is_status;
   logic [5:0]         entry_idx;
   logic               writer_elev;

   // Check decode
   logic [`PID_W-1:0]  eff_pid;
   logic               elevated;
   logic               fixed_periph;
   logic               known_periph;
   logic [5:0]         chk_entry;
   logic [2:0]         user_bit;
   logic               bit_grant;
   logic               grant;

   // Address and privilege decode for the register bus
   always_comb begin
      bus_req     = avs_read | avs_write;
      commit      = bus_req & ~wait_q;
      in_table    = (avs_address <= `ENTRY_LAST) &&
                    (avs_address[1:0] == 2'h0);
      is_status   = (avs_address == `STATUS_ADDR);
      entry_idx   = avs_address[7:2];
      writer_elev = (avs_pid == `PID_ELEV_LO) ||
                    (avs_pid == `PID_ELEV_HI);
   end

   // Decision for the current access
   always_comb begin
      eff_pid      = chk_req.vector_fetch ? `PID_VECTOR : chk_req.pid;
      elevated     = (eff_pid == `PID_ELEV_LO) ||
                     (eff_pid == `PID_ELEV_HI);
      known_periph = ({2'h0, chk_req.periph} < 8'(`NUM_PERIPH));
      fixed_periph = ({2'h0, chk_req.periph} < 8'(`NUM_FIXED));
      chk_entry    = chk_req.periph - 6'(`NUM_FIXED);
      user_bit     = eff_pid - `PID_FIRST_USER;
      bit_grant    = 1'b0;
      if (known_periph && !fixed_periph) begin
         bit_grant = perm_q[chk_entry][user_bit];
      end
      if (!known_periph) begin
         grant = 1'b0;
      end else if (elevated) begin
         grant = 1'b1;
      end else if (fixed_periph) begin
         grant = 1'b0;
      end else begin
         grant = bit_grant;
      end
   end

   // Next value of the result port and the refusal log
   always_comb begin
      resp_d        = resp_q;
      resp_d.valid  = chk_valid;
      log_d         = log_q;
      if (chk_valid) begin
         resp_d.grant  = grant;
         resp_d.periph = chk_req.periph;
      end
      // Clear by an elevated write of ones, a new event wins over it
      if (commit && avs_write && is_status && writer_elev &&
          avs_byteenable[0]) begin
         if (avs_writedata[`ST_ACC_REF_BIT]) begin
            log_d.acc_refused = 1'b0;
         end
         if (avs_writedata[`ST_WR_REF_BIT]) begin
            log_d.wr_refused = 1'b0;
         end
      end
      if (chk_valid && !grant) begin
         log_d.acc_refused = 1'b1;
         log_d.last_periph = chk_req.periph;
         log_d.last_pid    = eff_pid;
      end
      if (commit && avs_write && in_table && !writer_elev) begin
         log_d.wr_refused = 1'b1;
      end
   end

   // Next value of the permission table
   always_comb begin
      for (int i = 0; i < `NUM_ENTRY; i++) begin
         perm_d[i] = perm_q[i];
      end
      if (commit && avs_write && in_table && writer_elev &&
          avs_byteenable[0]) begin
         perm_d[entry_idx] = avs_writedata[`PERM_W-1:0];
      end
   end

   // Next value of the bus answer: one wait cycle, then the answer
   always_comb begin
      wait_d  = ~(bus_req & wait_q);
      rdata_d = rdata_q;
      if (bus_req && wait_q) begin
         rdata_d = 32'h0000_0000;
         if (avs_read && in_table) begin
            rdata_d[`PERM_W-1:0] = perm_q[entry_idx];
         end else if (avs_read && is_status) begin
            rdata_d[`ST_ACC_REF_BIT]               = log_q.acc_refused;
            rdata_d[`ST_WR_REF_BIT]                = log_q.wr_refused;
            rdata_d[`ST_PERIPH_LSB +: `PERIPH_W]   = log_q.last_periph;
            rdata_d[`ST_PID_LSB +: `PID_W]         = log_q.last_pid;
         end
      end
   end

   // Permission table registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `NUM_ENTRY; i++) begin
            perm_q[i] <= `PERM_RESET;
         end
      end else begin
         for (int i = 0; i < `NUM_ENTRY; i++) begin
            perm_q[i] <= perm_d[i];
         end
      end
   end

   // Bus, result and log registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
         resp_q  <= '0;
         log_q   <= '0;
      end else begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         resp_q  <= resp_d;
         log_q   <= log_d;
      end
   end

   // Outputs straight from flip-flops
   assign avs_waitrequest = wait_q;
   assign avs_readdata    = rdata_q;
   assign chk_resp        = resp_q;

endmodule

// *** src/access_guard_params.svh ***
// Offsets, field positions, reset values and counts of the access guard
`ifndef ACCESS_GUARD_PARAMS_SVH
`define ACCESS_GUARD_PARAMS_SVH

// Peripheral population
`define NUM_PERIPH        41
`define NUM_FIXED         7
`define NUM_ENTRY         34
`define PERIPH_W          6
`define PID_W             3
`define PERM_W            6

// Elevated, vector and first user process identifiers
`define PID_ELEV_LO       3'h0
`define PID_ELEV_HI       3'h1
`define PID_VECTOR        3'h0
`define PID_FIRST_USER    3'h2

// Register map, byte addresses
`define ADDR_W            8
`define ENTRY_BASE        8'h00
`define ENTRY_LAST        8'h84
`define STATUS_ADDR       8'h88

// Status register fields
`define ST_ACC_REF_BIT    0
`define ST_WR_REF_BIT     1
`define ST_PERIPH_LSB     4
`define ST_PID_LSB        12

// Reset values
`define PERM_RESET        6'h00
`define STATUS_RESET      32'h0000_0000

`endif

// *** src/access_guard_pkg.sv ***
// Types shared by the peripheral access guard
package access_guard_pkg;

   // One peripheral access from a CPU core
   typedef struct packed {
      logic [5:0] periph;
      logic [2:0] pid;
      logic       vector_fetch;
   } access_req_t;

   // Decision handed back for an access
   typedef struct packed {
      logic       valid;
      logic       grant;
      logic [5:0] periph;
   } access_resp_t;

   // Sticky record of refused attempts
   typedef struct packed {
      logic       acc_refused;
      logic       wr_refused;
      logic [5:0] last_periph;
      logic [2:0] last_pid;
   } refuse_log_t;

endpackage

// *** verif/guard_asserts.sv ***
// Port checks for the peripheral access guard
`timescale 1ns/1ps
`include "access_guard_params.svh"
module guard_asserts (
   input wire logic                          ref_clk,
   input wire logic                          arst_n,
   input wire logic                          avs_read,
   input wire logic                          avs_write,
   input wire logic                          avs_waitrequest,
   input wire logic                          chk_valid,
   input wire access_guard_pkg::access_req_t chk_req,
   input wire access_guard_pkg::access_resp_t chk_resp
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Bus request taken, answered once, then idle again
   sequence s_take; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
   chk_bus_answer: assert property (s_take |=> s_ans)
      else $error("bus answer not one cycle");
   chk_resp_pulse: assert property (chk_valid |=> chk_resp.valid)
      else $error("check not answered");
   chk_resp_idle: assert property (!chk_valid |=> !chk_resp.valid)
      else $error("answer without check");
   chk_periph_echo: assert property (chk_valid |=>
      chk_resp.periph == $past(chk_req.periph)) else $error("wrong index");
   chk_range_deny: assert property (chk_valid &&
      chk_req.periph >= `NUM_PERIPH |=> !chk_resp.grant)
      else $error("index out of range granted");
   chk_elev_grant: assert property (chk_valid && chk_req.pid < 3'h2 &&
      chk_req.periph < `NUM_PERIPH |=> chk_resp.grant)
      else $error("elevated refused");
   chk_vector_grant: assert property (chk_valid &&
      chk_req.vector_fetch && chk_req.periph < `NUM_PERIPH |=> chk_resp.grant)
      else $error("vector fetch refused");
   chk_fixed_deny: assert property (chk_valid && !chk_req.vector_fetch &&
      chk_req.pid > 3'h1 && chk_req.periph < `NUM_FIXED |=> !chk_resp.grant)
      else $error("critical block granted");
endmodule

// *** verif/cpu_core_model.sv ***
// CPU core issuing peripheral accesses tagged with its identifier
`timescale 1ns/1ps
module cpu_core_model (
   input  wire logic                     ref_clk,
   output logic                          chk_valid,
   output access_guard_pkg::access_req_t chk_req
);
   initial begin
      chk_valid = 1'b0;
      chk_req = '0;
   end
   // One access per call; fields scrambled once released
   task automatic issue(input logic [5:0] p, input logic [2:0] id,
                        input logic v);
      @(posedge ref_clk);
      chk_valid <= 1'b1;
      chk_req <= '{periph: p, pid: id, vector_fetch: v};
      @(posedge ref_clk);
      chk_valid <= 1'b0;
      chk_req <= ~chk_req;
   endtask
endmodule

// *** verif/peripheral_pid_access_guard_tb.sv ***
// Self-checking bench for the peripheral access guard
`timescale 1ns/1ps
`include "access_guard_params.svh"
module peripheral_pid_access_guard_tb;
   logic                           ref_clk = 1'b0;
   logic                           arst_n = 1'b0;
   logic [7:0]                     avs_address = 8'h00;
   logic                           avs_read = 1'b0;
   logic                           avs_write = 1'b0;
   logic [31:0]                    avs_writedata = 32'h0;
   logic [2:0]                     avs_pid = 3'h0;
   logic [31:0]                    avs_readdata;
   logic                           avs_waitrequest;
   logic                           chk_valid;
   access_guard_pkg::access_req_t  chk_req;
   access_guard_pkg::access_resp_t chk_resp;
   logic [31:0]                    rd;
   int                             fail_count = 0;
   int                             compares = 0;
   int                             cycles = 0;
   always #2.5 ref_clk = ~ref_clk;
   peripheral_pid_access_guard peripheral_pid_access_guard_inst (.ref_clk,
      .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_pid, .avs_readdata, .avs_waitrequest,
      .chk_valid, .chk_req, .chk_resp);
   cpu_core_model cpu_core_model_inst (.ref_clk, .chk_valid, .chk_req);
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Avalon cycle held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [2:0] id);
      @(posedge ref_clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      avs_pid <= id;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic probe(input int p, input int id, input int v, input int e);
      cpu_core_model_inst.issue(p[5:0], id[2:0], v[0]);
      @(negedge ref_clk);
      check({31'h0, chk_resp.grant}, e);
   endtask
   // Reset contents and an unmapped place
   task automatic t_reset();
      bus(1'b0, `ENTRY_BASE, 32'h0, 3'h0);
      check(rd, {26'h0, `PERM_RESET});
      bus(1'b0, `STATUS_ADDR, 32'h0, 3'h0);
      check(rd, `STATUS_RESET);
      bus(1'b0, 8'hFC, 32'h0, 3'h0);
      check(rd, 32'h0);
   endtask
   // One permission bit at a time against every user identifier
   task automatic t_map();
      for (int n = 0; n < 6; n++) begin
         bus(1'b1, `ENTRY_BASE, 32'h1 << n, n[2:0] & 3'h1);
         bus(1'b0, `ENTRY_BASE, 32'h0, 3'h1);
         check(rd, 32'h1 << n);
         for (int p = 2; p < 8; p++) probe(7, p, 0, p == n + 2);
      end
   endtask
   // Elevated, vector and critical cases across all peripherals
   task automatic t_elev();
      for (int p = 0; p < 41; p++) begin
         probe(p, p % 2, 0, 1);
         probe(p, 2 + p % 6, 1, 1);
         if (p < 7) probe(p, 2 + p % 6, 0, 0);
      end
      probe(63, 0, 0, 0);
   endtask
   // Entry writes from a user identifier are dropped and logged
   task automatic t_wguard();
      bus(1'b1, 8'h04, 32'h3F, 3'h4);
      bus(1'b0, 8'h04, 32'h0, 3'h0);
      check(rd, 32'h0);
      probe(8, 3, 0, 0);
      bus(1'b0, `STATUS_ADDR, 32'h0, 3'h0);
      check(rd, 32'h0000_3083);
      bus(1'b1, `STATUS_ADDR, 32'h3, 3'h5);
      bus(1'b0, `STATUS_ADDR, 32'h0, 3'h0);
      check(rd, 32'h0000_3083);
      bus(1'b1, `STATUS_ADDR, 32'h3, 3'h0);
      bus(1'b0, `STATUS_ADDR, 32'h0, 3'h0);
      check(rd, 32'h0000_3080);
      bus(1'b1, 8'h04, 32'h3F, 3'h1);
      bus(1'b0, 8'h04, 32'h0, 3'h1);
      check(rd, 32'h3F);
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_reset();
      t_map();
      t_elev();
      t_wguard();
      end_of_test();
   end
   // Hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         end_of_test();
      end
   end
endmodule
bind peripheral_pid_access_guard guard_asserts guard_asserts_inst (.ref_clk,
   .arst_n, .avs_read, .avs_write, .avs_waitrequest, .chk_valid, .chk_req,
   .chk_resp);
